// ### core/hpb_defines.svh
`ifndef HPB_DEFINES_SVH
`define HPB_DEFINES_SVH

// mode pin levels
`define HPB_STYLE_SPLIT 1'b0
`define HPB_STYLE_DSRW 1'b1
`define HPB_AMUX_MUXED 1'b0
`define HPB_AMUX_DEMUX 1'b1
// bus geometry
`define HPB_ADDR_W 7
`define HPB_DATA_W 8
`define HPB_ADDR_LO 7'h00
`define HPB_ADDR_HI 7'h7f
// unlock key for guarded registers, written by the host
`define HPB_UNLOCK_KEY 8'h95
// timing, in ns, and clock period in ns
`define HPB_CLK_PERIOD_NS 50
`define HPB_READBACK_NS 120
`define HPB_WR_SPACING_NS 120
// longest time rounds down, at least one cycle
`define HPB_READBACK_CYC ((`HPB_READBACK_NS / `HPB_CLK_PERIOD_NS) < 1 ? 1 : \
    (`HPB_READBACK_NS / `HPB_CLK_PERIOD_NS))
// cycles a strap needs to pass the pin filter after reset release
`define HPB_STRAP_SETTLE 4
// reset values
`define HPB_ADDR_RST 7'h00
`define HPB_DATA_RST 8'h00

`endif

// ### core/hpb_pkg.sv
`default_nettype none
package hpb_pkg;

    // access phases of the port
    typedef enum logic [3:0] {
        HPB_IDLE = 4'b0001,
        HPB_READ = 4'b0010,
        HPB_WRITE = 4'b0100,
        HPB_DONE = 4'b1000
    } hpb_state_t;

    // register-file request towards the device core
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [6:0] addr;
        logic [7:0] wdata;
    } hpb_req_t;

    // pin outputs
    typedef struct packed {
        logic [7:0] ad_out;
        logic ad_oe_b;
        logic rdy_out;
        logic rdy_oe_b;
    } hpb_pins_t;

endpackage
`default_nettype wire

// ### core/hpb_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpb_defines.svh"

// Functional notes
// - style pin: split strobes, or strobe plus direction
// - mux pin: shared or separate address bus
// - muxed address caught at ale fall, 7 bits
// - decode only addresses 00h through 7Fh
// - split style: read strobe reads, write writes
// - strobe style: direction high reads, low writes
// - chip select ORed with strobes, both active
// - ready output, asserted in the same cycle the read data turns valid
// - ready floats once the access ends
// - read drives data lines only while active
// - write captured at trailing edge of access
// - written value readable within read-back time
module hpb_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // mode straps
    input wire logic bus_style_select,
    input wire logic address_mux_select,
    // host control: strobes active low, direction high for read, ale active high
    input wire logic cs_b,
    input wire logic rd_b,
    input wire logic wr_b,
    input wire logic data_strobe_b,
    input wire logic rd_wr_dir,
    input wire logic ale,
    // address and data pins
    input wire logic [6:0] addr_in,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe_b,
    output logic rdy_out,
    output logic rdy_oe_b,
    // register file side
    output hpb_pkg::hpb_req_t reg_req,
    input wire logic [7:0] reg_rdata
);

    // control bits and buses come over one three-stage synchroniser each
    localparam int CW = 6;
    logic [CW-1:0] ctl_raw;
    logic [CW-1:0] ctl_s;
    logic [6:0] addr_s;
    logic [7:0] ad_s;

    assign ctl_raw = {cs_b, rd_b, wr_b, data_strobe_b, rd_wr_dir, ale};

    hpb_sync #(.WIDTH(CW), .RST_VAL(6'h3c)) u_sync_ctl (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(ctl_raw),
        .sync_out(ctl_s)
    );

    // bus values are sampled every cycle, not gated by the strobes, with the same latency as the strobes
    hpb_sync #(.WIDTH(`HPB_ADDR_W + `HPB_DATA_W), .RST_VAL('0)) u_sync_bus (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({addr_in, ad_in}),
        .sync_out({addr_s, ad_s})
    );

    // straps are pins too, so they pass the same filter before being frozen
    logic [1:0] strap_s;

    hpb_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_sync_strap (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({bus_style_select, address_mux_select}),
        .sync_out(strap_s)
    );

    logic cs_s;
    logic rd_s;
    logic wr_s;
    logic ds_s;
    logic dir_s;
    logic ale_s;
    assign {cs_s, rd_s, wr_s, ds_s, dir_s, ale_s} = ctl_s;

    typedef struct packed {
        hpb_pkg::hpb_state_t state;
        logic ale_q;
        logic [6:0] latch_addr;
        logic [6:0] acc_addr;
        logic [7:0] acc_data;
        logic [7:0] rdata;
        logic rdy;
        logic [2:0] wait_cnt;
        logic style;
        logic amux;
        logic straps_taken;
        logic [2:0] strap_wait;
        hpb_pkg::hpb_req_t req;
    } hpb_port_state_t;

    hpb_port_state_t st_reg;
    hpb_port_state_t st_next;

    logic access_rd;
    logic access_wr;
    logic [6:0] cur_addr;

    // combined strobe: chip select ORed with strobe, active access only when both are low
    always_comb begin
        access_rd = 1'b0;
        access_wr = 1'b0;
        if (st_reg.style == `HPB_STYLE_SPLIT) begin
            access_rd = !(cs_s | rd_s);
            access_wr = !(cs_s | wr_s);
        end else begin
            access_rd = !(cs_s | ds_s) && dir_s;
            access_wr = !(cs_s | ds_s) && !dir_s;
        end
    end

    // address source: latched at ale fall, or the separate bus live
    assign cur_addr = (st_reg.amux == `HPB_AMUX_MUXED) ? st_reg.latch_addr : addr_s;

    // next-state logic of the port
    always_comb begin
        st_next = st_reg;
        st_next.req.wr_en = 1'b0;
        st_next.req.rd_en = 1'b0;
        st_next.ale_q = ale_s;
        // straps are taken once the filter has settled after release, then frozen;
        // accesses wait for this, so a strobe seen earlier is only served afterwards
        if (!st_reg.straps_taken) begin
            if (st_reg.strap_wait == 3'(`HPB_STRAP_SETTLE)) begin
                st_next.style = strap_s[1];
                st_next.amux = strap_s[0];
                st_next.straps_taken = 1'b1;
            end else begin
                st_next.strap_wait = st_reg.strap_wait + 3'h1;
            end
        end
        if (st_reg.ale_q && !ale_s) begin
            st_next.latch_addr = ad_s[`HPB_ADDR_W-1:0];
        end
        case (st_reg.state)
            hpb_pkg::HPB_IDLE: begin
                st_next.rdy = 1'b0;
                st_next.wait_cnt = 3'd0;
                if (st_reg.straps_taken && access_rd) begin
                    st_next.acc_addr = cur_addr;
                    st_next.req.addr = cur_addr;
                    st_next.req.rd_en = (cur_addr >= `HPB_ADDR_LO) && (cur_addr <= `HPB_ADDR_HI);
                    st_next.state = hpb_pkg::HPB_READ;
                end else if (st_reg.straps_taken && access_wr) begin
                    st_next.rdy = 1'b1;
                    st_next.state = hpb_pkg::HPB_WRITE;
                end
            end
            hpb_pkg::HPB_READ: begin
                // data captured the cycle after the request, ready in that same cycle
                st_next.rdata = reg_rdata;
                st_next.rdy = 1'b1;
                if (!access_rd) begin
                    st_next.rdy = 1'b0;
                    st_next.state = hpb_pkg::HPB_IDLE;
                end
            end
            hpb_pkg::HPB_WRITE: begin
                // keep sampling so the values at the trailing edge are used
                st_next.acc_addr = cur_addr;
                st_next.acc_data = ad_s;
                if (!access_wr) begin
                    st_next.rdy = 1'b0;
                    st_next.req.addr = st_reg.acc_addr;
                    st_next.req.wdata = st_reg.acc_data;
                    st_next.req.wr_en = (st_reg.acc_addr <= `HPB_ADDR_HI);
                    st_next.state = hpb_pkg::HPB_DONE;
                end
            end
            hpb_pkg::HPB_DONE: begin
                // one quiet cycle; the register file takes the write at the edge that ends it
                if (st_reg.wait_cnt >= 3'(`HPB_READBACK_CYC - 2)) begin
                    st_next.state = hpb_pkg::HPB_IDLE;
                end else begin
                    st_next.wait_cnt = st_reg.wait_cnt + 3'd1;
                end
            end
            default: begin
                st_next.state = hpb_pkg::HPB_IDLE;
                st_next.rdy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '{
                state: hpb_pkg::HPB_IDLE,
                ale_q: 1'b0,
                latch_addr: `HPB_ADDR_RST,
                acc_addr: `HPB_ADDR_RST,
                acc_data: `HPB_DATA_RST,
                rdata: `HPB_DATA_RST,
                rdy: 1'b0,
                wait_cnt: 3'd0,
                style: 1'b0,
                amux: 1'b0,
                straps_taken: 1'b0,
                strap_wait: 3'h0,
                req: '0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs: data lines driven only in a live read, ready only while access holds
    always_comb begin
        ad_out = st_reg.rdata;
        ad_oe_b = !((st_reg.state == hpb_pkg::HPB_READ) && st_reg.rdy && access_rd);
        rdy_out = st_reg.rdy;
        rdy_oe_b = !(st_reg.rdy && (access_rd || access_wr));
    end

    assign reg_req = st_reg.req;

endmodule
`default_nettype wire

// ### core/hpb_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpb_defines.svh"

// three-stage synchroniser per bit; output changes once stages two and three agree
module hpb_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // asynchronous in, filtered out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } hpb_sync_state_t;

    hpb_sync_state_t st_reg;
    hpb_sync_state_t st_next;

    // s1 feeds s2 only; the agree filter looks at s2 and s3
    always_comb begin
        st_next = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.q;

endmodule
`default_nettype wire

// ### test/hpb_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module hpb_port_tb_top;
    logic clk, rst_b, sty, mux, cs_b, rd_b, wr_b, ds_b, dir, ale;
    logic [6:0] ai;
    logic [7:0] di, ad_out, rdata;
    logic ad_oe_b, rdy_out, rdy_oe_b;
    hpb_pkg::hpb_req_t req;
    int errors, comparisons, cyc, n;
    hpb_port u_hpb_port (.clk(clk), .rst_b(rst_b), .bus_style_select(sty), .address_mux_select(mux),
        .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .data_strobe_b(ds_b), .rd_wr_dir(dir), .ale(ale),
        .addr_in(ai), .ad_in(di), .ad_out(ad_out), .ad_oe_b(ad_oe_b), .rdy_out(rdy_out),
        .rdy_oe_b(rdy_oe_b), .reg_req(req), .reg_rdata(rdata));
    hpb_regs u_hpb_regs (.clk(clk), .reg_req(req), .reg_rdata(rdata));
    // clock
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            test_done;
        end
    end
    task automatic cy(input int k);
        repeat (k) @(negedge clk);
    endtask
    // straps are only taken after release, so each mode needs a reset
    task automatic boot(input logic s, input logic m);
        rst_b = 0;
        sty = s;
        mux = m;
        cy(10);
        rst_b = 1;
        cy(6);
    endtask
    // one host access; the ale and strobe phases are held past the synchroniser latency, the bus setup before the strobe is one cycle
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        if (mux == 1'b0) begin
            di = {1'b0, a};
            ale = 1;
            cy(5);
            ale = 0;
            cy(5);
        end
        // the unused address path carries a decoy so a wrong address source shows up
        ai = mux ? a : ~a;
        di = w ? d : {1'b1, ~a};
        dir = !w;
        cy(1);
        cs_b = 0;
        if (sty) ds_b = 0;
        else if (w) wr_b = 0;
        else rd_b = 0;
        n = 0;
        while (!(rdy_out === 1'b1 && (w || ad_oe_b === 1'b0)) && n < 20) begin
            cy(1);
            n++;
        end
        `CHK(n < 20, 1'b1)
        `CHK(rdy_oe_b, 1'b0)
        if (!w) `CHK(ad_out, d)
        cy(2);
        cs_b = 1;
        rd_b = 1;
        wr_b = 1;
        ds_b = 1;
        cy(8);
        `CHK({ad_oe_b, rdy_oe_b}, 2'b11)
        `CHK(u_hpb_regs.mem[a], d)
    endtask
    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            boot(i[1], i[0]);
            acc(1, 7'h15 + i[6:0], 8'h95 ^ i[7:0]);
            acc(0, 7'h15 + i[6:0], 8'h95 ^ i[7:0]);
        end
        $display("t_modes end");
    endtask
    task automatic t_bounds;
        boot(0, 0);
        acc(1, 7'h00, 8'haa);
        acc(1, 7'h7f, 8'h55);
        acc(0, 7'h00, 8'haa);
        acc(0, 7'h7f, 8'h55);
        $display("t_bounds end");
    endtask
    // strobe low with select high must do nothing; select alone frames it
    task automatic t_cs_frame;
        boot(0, 1);
        acc(1, 7'h40, 8'h3c);
        rd_b = 0;
        cy(10);
        `CHK({ad_oe_b, rdy_oe_b}, 2'b11)
        acc(0, 7'h40, 8'h3c);
        $display("t_cs_frame end");
    endtask
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        {rst_b, sty, mux, dir, ale} = 5'h00;
        {cs_b, rd_b, wr_b, ds_b} = 4'hf;
        ai = 7'h00;
        di = 8'h00;
        errors = 0;
        comparisons = 0;
        cyc = 0;
        t_modes;
        t_bounds;
        t_cs_frame;
        test_done;
    end
endmodule
`default_nettype wire

// ### test/hpb_props.sv
`timescale 1ns/1ps
`default_nettype none
module hpb_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // watched pins
    input wire logic cs_b,
    input wire logic ad_oe_b,
    input wire logic rdy_out,
    input wire logic rdy_oe_b,
    input wire hpb_pkg::hpb_req_t reg_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // select idle long enough for the synchroniser to drain
    sequence s_idle;
        cs_b [*8];
    endsequence
    a_rd_once: assert property (reg_req.rd_en |=> !reg_req.rd_en)
        else $error("read pulse too long");
    a_wr_once: assert property (reg_req.wr_en |=> !reg_req.wr_en)
        else $error("write pulse too long");
    a_rdy_read: assert property (reg_req.rd_en |=> rdy_out && !rdy_oe_b)
        else $error("ready missing after read");
    a_drive_ready: assert property (!ad_oe_b |-> !rdy_oe_b)
        else $error("data driven outside access");
    a_idle_float: assert property (s_idle |-> ad_oe_b && rdy_oe_b)
        else $error("pins still driven when idle");
    a_idle_quiet: assert property (s_idle |-> !reg_req.wr_en && !reg_req.rd_en)
        else $error("access without select");
    a_one_op: assert property (!(reg_req.rd_en && reg_req.wr_en))
        else $error("read and write together");
    a_wr_no_drive: assert property (reg_req.wr_en |-> ad_oe_b)
        else $error("bus driven in write");
endmodule
bind hpb_port hpb_props u_hpb_props (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .ad_oe_b(ad_oe_b),
    .rdy_out(rdy_out), .rdy_oe_b(rdy_oe_b), .reg_req(reg_req));
`default_nettype wire

// ### test/hpb_regs.sv
`timescale 1ns/1ps
`default_nettype none
module hpb_regs (
    // clock
    input wire logic clk,
    // request from the port
    input wire hpb_pkg::hpb_req_t reg_req,
    output logic [7:0] reg_rdata
);
    logic [7:0] mem [128];
    // each write pulse lands once; readable on the next cycle
    always_ff @(posedge clk) begin
        if (reg_req.wr_en) begin
            mem[reg_req.addr] <= reg_req.wdata;
        end
    end
    // read data follows the address with no delay
    assign reg_rdata = mem[reg_req.addr];
endmodule
`default_nettype wire
